/* File: fan_pwm_config_and_limits.sv */
// Limit registers, limit comparison, status and interrupt, and three fan drive channels.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module fan_pwm_config_and_limits #(
	parameter int unsigned SPIN_CYCLES [8] = fan_limits_pkg::SPIN_CYCLES_DEFAULT,
	parameter int unsigned RAMP_CYCLES = fan_limits_pkg::RAMP_CYCLES_DEFAULT
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rd_data_out,
	input fan_limits_pkg::temp_set_t temp_in,
	input wire logic temp_valid_in,
	input fan_limits_pkg::fan_counts_t fan_count_in,
	input wire logic [fan_limits_pkg::NUM_FAN-1:0] fan_count_valid_in,
	input wire logic [fan_limits_pkg::NUM_FAN-1:0] fan_speed_pulse_in,
	input fan_limits_pkg::temp_set_t auto_duty_in,
	output logic [fan_limits_pkg::NUM_DRIVE-1:0] pwm_out,
	output fan_limits_pkg::fan_counts_t fan_count_report_out,
	output logic single_channel_mode_out,
	output logic [2:0] single_channel_select_out,
	output logic irq_out
);
	import fan_limits_pkg::*;

	ctrl_reg_t ctrl_reg;
	ctrl_reg_t ctrl_next;
	logic [NUM_DRIVE-1:0] drive_off;
	logic [NUM_DRIVE-1:0] spin_timeout;
	logic [NUM_FAN-1:0] fan_edge;

	assign fan_edge = fan_speed_pulse_in & ~ctrl_reg.pulse_prev;

	genvar gd;
	generate
		for (gd = 0; gd < NUM_DRIVE; gd++) begin : g_drive
			fan_drive_channel #(
				.SPIN_CYCLES(SPIN_CYCLES),
				.RAMP_CYCLES(RAMP_CYCLES)
			) u_drive (
				.clk_in(clk_in),
				.rst_in(rst_in),
				.config_in(ctrl_reg.drive_cfg[gd]),
				.auto_duty_in(auto_duty_in),
				.manual_duty_in(ctrl_reg.manual_duty[gd]),
				.fan_edge_in(fan_edge[gd]),
				.pwm_out(pwm_out[gd]),
				.drive_off_out(drive_off[gd]),
				.spin_timeout_out(spin_timeout[gd])
			);
		end
	endgenerate

	always_comb begin
		logic [NUM_TEMP-1:0][7:0] temps;
		logic [2*NUM_TEMP-1:0] temp_set;
		logic [2*NUM_TEMP-1:0] temp_clr;
		logic [NUM_FAN-1:0] fan_set;
		logic [NUM_FAN-1:0] fan_clr;
		logic [15:0] limit;
		logic [15:0] count;
		temps = {temp_in.remote2, temp_in.local_ch, temp_in.remote1};
		temp_set = '0;
		temp_clr = '0;
		fan_set = '0;
		fan_clr = '0;
		limit = '0;
		count = '0;
		ctrl_next = ctrl_reg;
		ctrl_next.rd_data = 8'h00;
		ctrl_next.pulse_prev = fan_speed_pulse_in;

		// Register writes.
		if (wr_in) begin
			for (int i = 0; i < NUM_TEMP; i++) begin
				// Temperature limits ignore the lock.
				if (addr_in == TEMP_LOW_ADDR[i]) begin
					ctrl_next.temp_low[i] = wr_data_in;
				end
				if (addr_in == TEMP_HIGH_ADDR[i]) begin
					ctrl_next.temp_high[i] = wr_data_in;
				end
			end
			for (int i = 0; i < NUM_FAN; i++) begin
				if (addr_in == FAN_MIN_LOW_ADDR[i]) begin
					ctrl_next.fan_min_low[i] = wr_data_in;
				end
				if (addr_in == FAN_MIN_HIGH_ADDR[i]) begin
					if (i == 0 && ctrl_reg.single_mode) begin
						ctrl_next.fan_min_high[i][7:CHAN_SEL_LSB] = wr_data_in[7:CHAN_SEL_LSB];
					end else begin
						ctrl_next.fan_min_high[i] = wr_data_in;
					end
				end
			end
			for (int i = 0; i < NUM_DRIVE; i++) begin
				// Drive configuration freezes once the lock is set.
				if (addr_in == DRIVE_CONFIG_ADDR[i] && !ctrl_reg.lock) begin
					ctrl_next.drive_cfg[i] = drive_config_t'(wr_data_in);
				end
				if (addr_in == MANUAL_DUTY_ADDR[i] &&
					ctrl_reg.drive_cfg[i].behaviour_select == BHV_MANUAL) begin
					ctrl_next.manual_duty[i] = wr_data_in;
				end
			end
			// The lock can only be released by reset.
			if (addr_in == ADDR_LOCK_CONFIG && wr_data_in[LOCK_BIT]) begin
				ctrl_next.lock = 1'b1;
			end
			if (addr_in == ADDR_CONVERTER_CONFIG) begin
				ctrl_next.single_mode = wr_data_in[SINGLE_MODE_BIT];
			end
			if (addr_in == ADDR_TEMP_MASK) begin
				ctrl_next.temp_mask = wr_data_in[2*NUM_TEMP-1:0];
			end
			if (addr_in == ADDR_FAN_MASK) begin
				ctrl_next.fan_mask = wr_data_in[NUM_FAN-1:0];
			end
			if (addr_in == ADDR_TEMP_STATUS) begin
				temp_clr = wr_data_in[2*NUM_TEMP-1:0];
			end
			if (addr_in == ADDR_FAN_STATUS) begin
				fan_clr = wr_data_in[NUM_FAN-1:0];
			end
		end

		// Temperature limit comparison on signed readings.
		if (temp_valid_in) begin
			for (int i = 0; i < NUM_TEMP; i++) begin
				temp_set[2*i] = $signed(temps[i]) <= $signed(ctrl_reg.temp_low[i]);
				temp_set[2*i+1] = $signed(temps[i]) > $signed(ctrl_reg.temp_high[i]);
			end
		end

		// Fan speed measurement and limit comparison.
		for (int i = 0; i < NUM_FAN; i++) begin
			if (fan_edge[i]) begin
				ctrl_next.pulse_seen[i] = 1'b1;
			end
			// Arm the stall check for the measurement that follows a failed spin-up.
			if (spin_timeout[FAN_DRIVE_MAP[i]]) begin
				ctrl_next.await_meas[i] = 1'b1;
				ctrl_next.pulse_seen[i] = 1'b0;
			end
			if (i == 0 && ctrl_reg.single_mode) begin
				// The upper bits are a channel select, so only the low byte limits fan 1.
				limit = {8'h00, ctrl_reg.fan_min_low[i]};
			end else begin
				limit = {ctrl_reg.fan_min_high[i], ctrl_reg.fan_min_low[i]};
			end
			if (fan_count_valid_in[i]) begin
				if (ctrl_reg.await_meas[i] && !ctrl_reg.pulse_seen[i] && !fan_edge[i]) begin
					count = FAN_COUNT_STALLED;
				end else begin
					count = fan_count_in[i];
				end
				ctrl_next.report[i] = count;
				ctrl_next.await_meas[i] = 1'b0;
				fan_set[i] = (count > limit) &&
					(limit != FAN_LIMIT_NONE_LOW) && (limit != FAN_LIMIT_NONE_HIGH) &&
					!drive_off[FAN_DRIVE_MAP[i]];
			end
		end

		// A new event beats a clear arriving in the same cycle.
		ctrl_next.temp_status = (ctrl_reg.temp_status & ~temp_clr) | temp_set;
		ctrl_next.fan_status = (ctrl_reg.fan_status & ~fan_clr) | fan_set;

		// Register reads; the data stands only in the following cycle.
		if (rd_in) begin
			for (int i = 0; i < NUM_TEMP; i++) begin
				if (addr_in == TEMP_LOW_ADDR[i]) begin
					ctrl_next.rd_data = ctrl_reg.temp_low[i];
				end
				if (addr_in == TEMP_HIGH_ADDR[i]) begin
					ctrl_next.rd_data = ctrl_reg.temp_high[i];
				end
			end
			for (int i = 0; i < NUM_FAN; i++) begin
				if (addr_in == FAN_MIN_LOW_ADDR[i]) begin
					ctrl_next.rd_data = ctrl_reg.fan_min_low[i];
				end
				if (addr_in == FAN_MIN_HIGH_ADDR[i]) begin
					if (i == 0 && ctrl_reg.single_mode) begin
						ctrl_next.rd_data = {ctrl_reg.fan_min_high[i][7:CHAN_SEL_LSB], 5'h00};
					end else begin
						ctrl_next.rd_data = ctrl_reg.fan_min_high[i];
					end
				end
			end
			for (int i = 0; i < NUM_DRIVE; i++) begin
				if (addr_in == DRIVE_CONFIG_ADDR[i]) begin
					ctrl_next.rd_data = ctrl_reg.drive_cfg[i];
				end
				if (addr_in == MANUAL_DUTY_ADDR[i]) begin
					ctrl_next.rd_data = ctrl_reg.manual_duty[i];
				end
			end
			if (addr_in == ADDR_LOCK_CONFIG) begin
				ctrl_next.rd_data[LOCK_BIT] = ctrl_reg.lock;
			end
			if (addr_in == ADDR_CONVERTER_CONFIG) begin
				ctrl_next.rd_data[SINGLE_MODE_BIT] = ctrl_reg.single_mode;
			end
			if (addr_in == ADDR_TEMP_STATUS) begin
				ctrl_next.rd_data = {2'h0, ctrl_reg.temp_status};
			end
			if (addr_in == ADDR_FAN_STATUS) begin
				ctrl_next.rd_data = {4'h0, ctrl_reg.fan_status};
			end
			if (addr_in == ADDR_TEMP_MASK) begin
				ctrl_next.rd_data = {2'h0, ctrl_reg.temp_mask};
			end
			if (addr_in == ADDR_FAN_MASK) begin
				ctrl_next.rd_data = {4'h0, ctrl_reg.fan_mask};
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_reg <= CTRL_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	assign rd_data_out = ctrl_reg.rd_data;
	assign fan_count_report_out = ctrl_reg.report;
	assign single_channel_mode_out = ctrl_reg.single_mode;
	assign single_channel_select_out = ctrl_reg.single_mode ?
		ctrl_reg.fan_min_high[0][7:CHAN_SEL_LSB] : 3'h0;
	assign irq_out = |(ctrl_reg.temp_status & ctrl_reg.temp_mask) ||
		|(ctrl_reg.fan_status & ctrl_reg.fan_mask);

endmodule // fan_pwm_config_and_limits

/* File: fan_limits_pkg.sv */
// Constants, register map and shared types for the fan limit and drive configuration block.
// What this block does
// - Temperature past a limit sets its status flag.
// - Limit registers stay writable despite the lock.
// - High event only when value exceeds limit.
// - Low event when value at or below limit.
// - Period count above minimum flags slow fan.
// - Single-channel mode repurposes fan 1 high byte.
// - Spin-up drives full until two edges or timeout.
// - No pulse after timeout reports all ones, faults.
// - All-zeros limit never raises fault, nor does all-ones except on fan 1 in single-channel mode.
// - Timeout codes: none, 100 ms ... 4 s.
// - Slow bit stretches ramp rates fourfold.
// - Invert bit selects output polarity.
// - Codes 000-010 follow one temperature channel.
// - Code 011 full speed, 100 disables.
// - Codes 101, 110 take fastest calculated speed.
// - Code 111 is manual, duty registers writable.
// - Fan flag suppressed while its drive is off.
package fan_limits_pkg;

	localparam int unsigned CLK_KHZ = 25000;
	localparam int NUM_TEMP = 3;
	localparam int NUM_FAN = 4;
	localparam int NUM_DRIVE = 3;

	// Register offsets.
	localparam logic [7:0] TEMP_LOW_ADDR [NUM_TEMP] = '{8'h4E, 8'h50, 8'h52};
	localparam logic [7:0] TEMP_HIGH_ADDR [NUM_TEMP] = '{8'h4F, 8'h51, 8'h53};
	localparam logic [7:0] FAN_MIN_LOW_ADDR [NUM_FAN] = '{8'h54, 8'h56, 8'h58, 8'h5A};
	localparam logic [7:0] FAN_MIN_HIGH_ADDR [NUM_FAN] = '{8'h55, 8'h57, 8'h59, 8'h5B};
	localparam logic [7:0] DRIVE_CONFIG_ADDR [NUM_DRIVE] = '{8'h5C, 8'h5D, 8'h5E};
	localparam logic [7:0] MANUAL_DUTY_ADDR [NUM_DRIVE] = '{8'h30, 8'h31, 8'h32};
	localparam logic [7:0] ADDR_LOCK_CONFIG = 8'h40;
	localparam logic [7:0] ADDR_TEMP_STATUS = 8'h41;
	localparam logic [7:0] ADDR_FAN_STATUS = 8'h42;
	localparam logic [7:0] ADDR_CONVERTER_CONFIG = 8'h73;
	localparam logic [7:0] ADDR_TEMP_MASK = 8'h74;
	localparam logic [7:0] ADDR_FAN_MASK = 8'h75;

	// Field positions.
	localparam int LOCK_BIT = 0;
	localparam int SINGLE_MODE_BIT = 6;
	localparam int CHAN_SEL_LSB = 5;

	// Values after reset, and the fan limit and count codes with a special meaning.
	localparam logic [7:0] TEMP_LOW_RESET = 8'h81;
	localparam logic [7:0] TEMP_HIGH_RESET = 8'h7F;
	localparam logic [7:0] FAN_MIN_RESET = 8'hFF;
	localparam logic [7:0] DRIVE_CONFIG_RESET = 8'h82;
	localparam logic [15:0] FAN_LIMIT_NONE_LOW = 16'h0000;
	localparam logic [15:0] FAN_LIMIT_NONE_HIGH = 16'hFFFF;
	localparam logic [15:0] FAN_COUNT_STALLED = 16'hFFFF;

	// Fans 3 and 4 share the third drive output.
	localparam int FAN_DRIVE_MAP [NUM_FAN] = '{0, 1, 2, 2};

	// Startup timeouts in milliseconds per code, and their cycle counts.
	localparam int unsigned SPIN_TIME_MS [8] = '{0, 100, 250, 400, 667, 1000, 2000, 4000};
	localparam int unsigned SPIN_CYCLES_DEFAULT [8] = '{
		SPIN_TIME_MS[0] * CLK_KHZ, SPIN_TIME_MS[1] * CLK_KHZ,
		SPIN_TIME_MS[2] * CLK_KHZ, SPIN_TIME_MS[3] * CLK_KHZ,
		SPIN_TIME_MS[4] * CLK_KHZ, SPIN_TIME_MS[5] * CLK_KHZ,
		SPIN_TIME_MS[6] * CLK_KHZ, SPIN_TIME_MS[7] * CLK_KHZ};
	localparam int SPIN_TIMER_W = 27;

	// One duty step of the acoustic ramp, in microseconds, and its cycle count.
	localparam int unsigned RAMP_STEP_US = 1000;
	localparam int unsigned RAMP_CYCLES_DEFAULT = RAMP_STEP_US * CLK_KHZ / 1000;
	localparam int unsigned SLOW_FACTOR = 4;
	localparam int RAMP_TIMER_W = 19;

	typedef enum logic [2:0] {
		BHV_REMOTE1 = 3'h0,
		BHV_LOCAL = 3'h1,
		BHV_REMOTE2 = 3'h2,
		BHV_FULL = 3'h3,
		BHV_DISABLED = 3'h4,
		BHV_LOCAL_REMOTE2 = 3'h5,
		BHV_ALL = 3'h6,
		BHV_MANUAL = 3'h7
	} behaviour_t;

	typedef struct packed {
		behaviour_t behaviour_select;
		logic output_invert;
		logic slow_ramp;
		logic [2:0] spin_timeout;
	} drive_config_t;

	typedef struct packed {
		logic [7:0] remote2;
		logic [7:0] local_ch;
		logic [7:0] remote1;
	} temp_set_t;

	typedef logic [NUM_FAN-1:0][15:0] fan_counts_t;

	typedef enum {DRIVE_OFF, DRIVE_SPIN, DRIVE_RUN} drive_state_t;

	typedef struct packed {
		drive_state_t fsm;
		logic [SPIN_TIMER_W-1:0] timer;
		logic edge_seen;
		logic [7:0] duty;
		logic [RAMP_TIMER_W-1:0] ramp;
		logic [7:0] pwm_cnt;
		logic pwm;
		logic timeout;
	} drive_reg_t;

	typedef struct packed {
		logic [NUM_TEMP-1:0][7:0] temp_low;
		logic [NUM_TEMP-1:0][7:0] temp_high;
		logic [NUM_FAN-1:0][7:0] fan_min_low;
		logic [NUM_FAN-1:0][7:0] fan_min_high;
		drive_config_t [NUM_DRIVE-1:0] drive_cfg;
		logic [NUM_DRIVE-1:0][7:0] manual_duty;
		logic single_mode;
		logic lock;
		logic [2*NUM_TEMP-1:0] temp_status;
		logic [2*NUM_TEMP-1:0] temp_mask;
		logic [NUM_FAN-1:0] fan_status;
		logic [NUM_FAN-1:0] fan_mask;
		logic [7:0] rd_data;
		logic [NUM_FAN-1:0] pulse_prev;
		logic [NUM_FAN-1:0] await_meas;
		logic [NUM_FAN-1:0] pulse_seen;
		fan_counts_t report;
	} ctrl_reg_t;

	localparam ctrl_reg_t CTRL_RESET = '{
		temp_low: {NUM_TEMP{TEMP_LOW_RESET}},
		temp_high: {NUM_TEMP{TEMP_HIGH_RESET}},
		fan_min_low: {NUM_FAN{FAN_MIN_RESET}},
		fan_min_high: {NUM_FAN{FAN_MIN_RESET}},
		drive_cfg: {NUM_DRIVE{DRIVE_CONFIG_RESET}},
		// Idle speed lines rest at their pull-up level, so a low history would fake an edge.
		pulse_prev: '1,
		default: '0};

endpackage

/* File: fan_drive_channel.sv */
// One fan drive channel: source selection, spin-up, ramp and PWM output.
`timescale 1ns/1ps
module fan_drive_channel #(
	parameter int unsigned SPIN_CYCLES [8] = fan_limits_pkg::SPIN_CYCLES_DEFAULT,
	parameter int unsigned RAMP_CYCLES = fan_limits_pkg::RAMP_CYCLES_DEFAULT
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input fan_limits_pkg::drive_config_t config_in,
	input fan_limits_pkg::temp_set_t auto_duty_in,
	input wire logic [7:0] manual_duty_in,
	input wire logic fan_edge_in,
	output logic pwm_out,
	output logic drive_off_out,
	output logic spin_timeout_out
);
	import fan_limits_pkg::*;

	drive_reg_t drive_reg;
	drive_reg_t drive_next;

	always_comb begin
		logic [7:0] target;
		logic [7:0] fast_two;
		logic ramped;
		logic [RAMP_TIMER_W-1:0] step;
		target = 8'h00;
		fast_two = (auto_duty_in.local_ch > auto_duty_in.remote2) ?
			auto_duty_in.local_ch : auto_duty_in.remote2;
		ramped = 1'b0;
		step = config_in.slow_ramp ? RAMP_TIMER_W'(RAMP_CYCLES * SLOW_FACTOR) :
			RAMP_TIMER_W'(RAMP_CYCLES);
		drive_next = drive_reg;
		drive_next.timeout = 1'b0;
		unique case (config_in.behaviour_select)
			BHV_REMOTE1: begin
				target = auto_duty_in.remote1;
				ramped = 1'b1;
			end
			BHV_LOCAL: begin
				target = auto_duty_in.local_ch;
				ramped = 1'b1;
			end
			BHV_REMOTE2: begin
				target = auto_duty_in.remote2;
				ramped = 1'b1;
			end
			BHV_FULL: target = 8'hFF;
			BHV_DISABLED: target = 8'h00;
			BHV_LOCAL_REMOTE2: begin
				target = fast_two;
				ramped = 1'b1;
			end
			BHV_ALL: begin
				target = (fast_two > auto_duty_in.remote1) ? fast_two : auto_duty_in.remote1;
				ramped = 1'b1;
			end
			BHV_MANUAL: target = manual_duty_in;
		endcase
		unique case (drive_reg.fsm)
			DRIVE_OFF: begin
				drive_next.duty = 8'h00;
				if (config_in.behaviour_select != BHV_DISABLED) begin
					// Code zero means no spin-up phase at all.
					if (config_in.spin_timeout == 3'h0) begin
						drive_next.fsm = DRIVE_RUN;
					end else begin
						drive_next.fsm = DRIVE_SPIN;
						drive_next.timer = SPIN_TIMER_W'(SPIN_CYCLES[config_in.spin_timeout]);
						drive_next.edge_seen = 1'b0;
					end
				end
			end
			DRIVE_SPIN: begin
				drive_next.duty = 8'hFF;
				if (config_in.behaviour_select == BHV_DISABLED) begin
					drive_next.fsm = DRIVE_OFF;
				end else if (fan_edge_in && drive_reg.edge_seen) begin
					drive_next.fsm = DRIVE_RUN;
				end else begin
					if (fan_edge_in) begin
						drive_next.edge_seen = 1'b1;
					end
					if (drive_reg.timer <= SPIN_TIMER_W'(1)) begin
						drive_next.fsm = DRIVE_RUN;
						drive_next.timeout = 1'b1;
					end else begin
						drive_next.timer = drive_reg.timer - SPIN_TIMER_W'(1);
					end
				end
			end
			DRIVE_RUN: begin
				if (config_in.behaviour_select == BHV_DISABLED) begin
					drive_next.fsm = DRIVE_OFF;
					drive_next.duty = 8'h00;
				end else if (!ramped) begin
					drive_next.duty = target;
				end else if (drive_reg.ramp == '0) begin
					// Automatic modes move one step at a time to keep fan noise changes gentle.
					drive_next.ramp = step - RAMP_TIMER_W'(1);
					if (drive_reg.duty < target) begin
						drive_next.duty = drive_reg.duty + 8'h01;
					end else if (drive_reg.duty > target) begin
						drive_next.duty = drive_reg.duty - 8'h01;
					end
				end else begin
					drive_next.ramp = drive_reg.ramp - RAMP_TIMER_W'(1);
				end
			end
		endcase
		drive_next.pwm_cnt = drive_reg.pwm_cnt + 8'h01;
		drive_next.pwm = ((drive_reg.duty == 8'hFF) || (drive_reg.pwm_cnt < drive_reg.duty)) ^
			config_in.output_invert;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			drive_reg <= '0;
		end else begin
			drive_reg <= drive_next;
		end
	end

	assign pwm_out = drive_reg.pwm;
	assign drive_off_out = (drive_reg.fsm == DRIVE_OFF);
	assign spin_timeout_out = drive_reg.timeout;

endmodule // fan_drive_channel

/* File: fan_limits_props.sv */
// Port-level assertions for the fan limit and drive configuration block.
`timescale 1ns/1ps
module fan_limits_props (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [7:0] rd_data_out,
	input fan_limits_pkg::fan_counts_t fan_count_in,
	input wire logic [fan_limits_pkg::NUM_FAN-1:0] fan_count_valid_in,
	input wire logic [fan_limits_pkg::NUM_DRIVE-1:0] pwm_out,
	input fan_limits_pkg::fan_counts_t fan_count_report_out,
	input wire logic single_channel_mode_out,
	input wire logic [2:0] single_channel_select_out,
	input wire logic irq_out
);
	import fan_limits_pkg::*;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	a_reset_quiet: assert property (
		$fell(rst_in) |-> pwm_out == 3'h0 && irq_out == 1'b0) else $error("outputs busy after reset");
	a_select_gated: assert property (
		!single_channel_mode_out |-> single_channel_select_out == 3'h0) else $error("select leaks");
	a_select_write: assert property (
		wr_in && addr_in == 8'h55 && single_channel_mode_out
		|=> single_channel_select_out == $past(wr_data_in[7:5])) else $error("select not written");
	a_mode_write: assert property (
		wr_in && addr_in == 8'h73 |=> single_channel_mode_out == $past(wr_data_in[6]))
		else $error("mode bit not written");
	a_limit_readback: assert property (
		(wr_in && addr_in == 8'h4F) ##1 (rd_in && addr_in == 8'h4F)
		|=> rd_data_out == $past(wr_data_in, 2)) else $error("limit readback wrong");
	a_report_count: assert property (
		fan_count_valid_in[0] |=> fan_count_report_out[0] == $past(fan_count_in[0])
		|| fan_count_report_out[0] == 16'hFFFF) else $error("fan report wrong");
	a_disabled_level: assert property (
		wr_in && addr_in == 8'h5E && wr_data_in[7:5] == 3'h4
		|-> ##4 pwm_out[2] == $past(wr_data_in[4], 4)) else $error("disabled level wrong");
	a_full_level: assert property (
		wr_in && addr_in == 8'h5E && wr_data_in[7:5] == 3'h3 && wr_data_in[2:0] == 3'h0
		|-> ##4 pwm_out[2] == !$past(wr_data_in[4], 4)) else $error("full level wrong");
endmodule // fan_limits_props

bind fan_pwm_config_and_limits fan_limits_props u_props (
	.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
	.wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .fan_count_in(fan_count_in),
	.fan_count_valid_in(fan_count_valid_in), .pwm_out(pwm_out),
	.fan_count_report_out(fan_count_report_out),
	.single_channel_mode_out(single_channel_mode_out),
	.single_channel_select_out(single_channel_select_out), .irq_out(irq_out));

/* File: fan_fan_speed_pulse_model.sv */
// Behavioural fan whose speed output toggles while it turns.
`timescale 1ns/1ps
module fan_fan_speed_pulse_model #(
	parameter int HALF = 8
) (
	input wire logic clk_in,
	input wire logic run_in,
	output logic pulse_out
);
	int cnt = 0;
	initial pulse_out = 1'b1;
	// A stopped rotor leaves the open-collector line at its pull-up level, so no edges appear.
	always @(posedge clk_in) begin
		if (!run_in) begin
			cnt <= 0;
			pulse_out <= 1'b1;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			pulse_out <= ~pulse_out;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule // fan_fan_speed_pulse_model

/* File: fan_pwm_config_and_limits_tb_top.sv */
// Self-checking bench for the fan limit and drive configuration block.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
	$display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module fan_pwm_config_and_limits_tb_top;
	import fan_limits_pkg::*;
	localparam int unsigned SPIN_SIM [8] = '{0, 50, 100, 150, 200, 250, 300, 350};
	localparam logic [7:0] CFGS [10] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h80, 8'hA0, 8'hC0,
		8'hE0, 8'h70, 8'h90};
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] addr_in = 8'h00;
	logic [7:0] wr_data_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [7:0] rd_data_out;
	temp_set_t temp_in = '0;
	logic temp_valid_in = 1'b0;
	fan_counts_t fan_count_in = '0;
	logic [3:0] fan_count_valid_in = 4'h0;
	wire logic [3:0] fan_speed_pulse;
	logic [3:0] fan_run = 4'hE;
	temp_set_t auto_duty_in = '0;
	logic [2:0] pwm_out;
	fan_counts_t fan_count_report_out;
	logic single_channel_mode_out;
	logic [2:0] single_channel_select_out;
	logic irq_out;
	int mismatches = 0;
	int n_compared = 0;
	int cycles = 0;
	logic signed [7:0] lo [3];
	logic signed [7:0] hi [3];
	logic [15:0] lim [4];
	logic [7:0] man;

	initial begin
		forever #20 clk_in = ~clk_in;
	end

	for (genvar g = 0; g < 4; g++) begin : fans
		fan_fan_speed_pulse_model #(.HALF(8)) u_fan (.clk_in(clk_in), .run_in(fan_run[g]),
			.pulse_out(fan_speed_pulse[g]));
	end

	fan_pwm_config_and_limits #(.SPIN_CYCLES(SPIN_SIM), .RAMP_CYCLES(4)) DUT (
		.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
		.wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .temp_in(temp_in),
		.temp_valid_in(temp_valid_in), .fan_count_in(fan_count_in),
		.fan_count_valid_in(fan_count_valid_in), .fan_speed_pulse_in(fan_speed_pulse),
		.auto_duty_in(auto_duty_in), .pwm_out(pwm_out),
		.fan_count_report_out(fan_count_report_out),
		.single_channel_mode_out(single_channel_mode_out),
		.single_channel_select_out(single_channel_select_out), .irq_out(irq_out));

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wr_data_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask

	// Starts in the current cycle, so it may directly follow a write with no gap.
	task automatic rd_now(input logic [7:0] a, input logic [7:0] e);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		`CHK(rd_data_out, e)
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_in);
		rd_now(a, e);
	endtask

	task automatic pulse_temp(input temp_set_t t);
		@(posedge clk_in);
		temp_in <= t;
		temp_valid_in <= 1'b1;
		@(posedge clk_in);
		temp_valid_in <= 1'b0;
	endtask

	task automatic pulse_fan(input fan_counts_t c, input logic [3:0] v);
		@(posedge clk_in);
		fan_count_in <= c;
		fan_count_valid_in <= v;
		@(posedge clk_in);
		fan_count_valid_in <= 4'h0;
		@(negedge clk_in);
	endtask

	function automatic logic [5:0] temp_flags(input temp_set_t t);
		logic signed [7:0] v [3];
		v = '{t.remote1, t.local_ch, t.remote2};
		for (int i = 0; i < 3; i++) begin
			temp_flags[2*i] = v[i] <= lo[i];
			temp_flags[2*i+1] = v[i] > hi[i];
		end
	endfunction

	function automatic logic [3:0] fan_flags(input fan_counts_t c, input logic [3:0] on);
		for (int i = 0; i < 4; i++)
			fan_flags[i] = on[i] && c[i] > lim[i] && lim[i] != 16'h0000 && lim[i] != 16'hFFFF;
	endfunction

	// High cycles expected in one 256-cycle frame of the third drive.
	function automatic int exp_high(input logic [7:0] cfg);
		int d;
		int r1;
		int lc;
		int r2;
		r1 = auto_duty_in.remote1;
		lc = auto_duty_in.local_ch;
		r2 = auto_duty_in.remote2;
		case (cfg[7:5])
			3'h0: d = r1;
			3'h1: d = lc;
			3'h2: d = r2;
			3'h3: d = 255;
			3'h4: d = 0;
			3'h5: d = (lc > r2) ? lc : r2;
			3'h6: d = (r1 > ((lc > r2) ? lc : r2)) ? r1 : ((lc > r2) ? lc : r2);
			default: d = man;
		endcase
		if (d == 255)
			d = 256;
		return cfg[4] ? 256 - d : d;
	endfunction

	initial begin
		logic [7:0] d;
		temp_set_t t;
		fan_counts_t c;
		int n;
		void'($urandom(32'hA7ECDBB7));
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		for (int a = 8'h4E; a <= 8'h5E; a++)
			rd(8'(a), a < 8'h54 ? (a[0] ? 8'h7F : 8'h81) : (a < 8'h5C ? 8'hFF : 8'h82));
		rd(8'h20, 8'h00);
		for (int a = 8'h4E; a <= 8'h5B; a++) begin
			d = 8'($urandom);
			wr(8'(a), d);
			rd(8'(a), d);
		end
		d = 8'($urandom);
		wr(8'h4F, d);
		rd_now(8'h4F, d);
		wr(8'h73, 8'h40);
		wr(8'h55, 8'hA7);
		rd(8'h55, 8'hA0);
		`CHK(single_channel_select_out, 3'h5)
		wr(8'h73, 8'h00);
		lim = '{16'h1000, 16'hFFFF, 16'h0000, 16'(($urandom % 32'hE000) + 32'h0100)};
		for (int i = 0; i < 4; i++) begin
			wr(FAN_MIN_LOW_ADDR[i], lim[i][7:0]);
			wr(FAN_MIN_HIGH_ADDR[i], lim[i][15:8]);
		end
		wr(8'h75, 8'h0F);
		wr(8'h5C, 8'h01);
		repeat (4) @(negedge clk_in);
		`CHK(pwm_out[0], 1'b1)
		repeat (60) @(posedge clk_in);
		pulse_fan({lim[3], lim[2], lim[1], 16'h0123}, 4'h1);
		`CHK(fan_count_report_out[0], 16'hFFFF)
		rd(8'h42, 8'h01);
		`CHK(irq_out, 1'b1)
		wr(8'h42, 8'h0F);
		wr(8'h5D, 8'hE7);
		repeat (4) @(negedge clk_in);
		`CHK(pwm_out[1], 1'b1)
		repeat (120) @(negedge clk_in);
		`CHK(pwm_out[1], 1'b0)
		pulse_fan({lim[3] + 16'h1, lim[2], lim[1], lim[0]}, 4'hF);
		rd(8'h42, 8'h00);
		wr(8'h5E, 8'h60);
		pulse_fan({lim[3], 16'h8000, 16'hFFFF, lim[0]}, 4'hF);
		rd(8'h42, 8'h00);
		c = {lim[3] + 16'h1, 16'hFFFF, 16'hFFFF, lim[0] + 16'h1};
		pulse_fan(c, 4'hF);
		`CHK(fan_count_report_out, c)
		rd(8'h42, {4'h0, fan_flags(c, 4'hF)});
		wr(8'h42, 8'h0F);
		rd(8'h42, 8'h00);
		`CHK(irq_out, 1'b0)
		wr(8'h74, 8'h3F);
		for (int i = 0; i < 3; i++) begin
			hi[i] = 8'($urandom_range(100));
			lo[i] = hi[i] - 8'($urandom_range(60, 3));
			wr(TEMP_LOW_ADDR[i], lo[i]);
			wr(TEMP_HIGH_ADDR[i], hi[i]);
		end
		for (int j = 0; j < 8; j++) begin
			case (j)
				0: t = {hi[2], hi[1], hi[0]};
				1: t = {hi[2] + 8'h1, hi[1] + 8'h1, hi[0] + 8'h1};
				2: t = {lo[2], lo[1], lo[0]};
				3: t = {lo[2] + 8'h1, lo[1] + 8'h1, lo[0] + 8'h1};
				default: t = 24'($urandom);
			endcase
			pulse_temp(t);
			rd(8'h41, {2'h0, temp_flags(t)});
			`CHK(irq_out, temp_flags(t) != 6'h0)
			if (j == 1) begin
				wr(8'h74, 8'h00);
				@(negedge clk_in);
				`CHK(irq_out, 1'b0)
				wr(8'h74, 8'h3F);
			end
			wr(8'h41, 8'h3F);
			rd(8'h41, 8'h00);
		end
		@(posedge clk_in);
		auto_duty_in <= 24'($urandom);
		man = 8'($urandom);
		for (int k = 0; k < 10; k++) begin
			wr(8'h5E, CFGS[k]);
			if (CFGS[k][7:5] == 3'h7)
				wr(8'h32, man);
			repeat (1100) @(negedge clk_in);
			n = 0;
			repeat (256) begin
				@(negedge clk_in);
				n += (pwm_out[2] === 1'b1);
			end
			`CHK(n, exp_high(CFGS[k]))
		end
		// A slow ramp from zero toward full duty is still far from full after 1100 cycles.
		@(posedge clk_in);
		auto_duty_in <= 24'hFFFFFF;
		wr(8'h5E, 8'h08);
		repeat (1100) @(negedge clk_in);
		n = 0;
		repeat (256) begin
			@(negedge clk_in);
			n += (pwm_out[2] === 1'b1);
		end
		`CHK(n < 200, 1'b1)
		report_and_stop();
	end

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			$display("mismatch at %0t: run did not finish in time", $time);
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("compared %0d values, %0d mismatches", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
endmodule // fan_pwm_config_and_limits_tb_top
